// File: core/tcc_pkg.sv
// Constants shared by the capture/compare channels and their interrupt logic.
// Assumes a 16-bit counter kept outside this block.
package tcc_pkg;
  localparam int TCC_CNT_W = 16;
  localparam int TCC_MAX_CH = 7;
  // Channel control word layout
  localparam int TCC_CM_LSB = 14;
  localparam int TCC_CCIS_LSB = 12;
  localparam int TCC_SCS_BIT = 11;
  localparam int TCC_SYNCED_INPUT_BIT_BIT = 10;
  localparam int TCC_CAP_BIT = 8;
  localparam int TCC_OUTMOD_LSB = 5;
  localparam int TCC_CHANNEL_IRQ_ENABLE_BIT = 4;
  localparam int TCC_CCI_BIT = 3;
  localparam int TCC_OUT_BIT = 2;
  localparam int TCC_COV_BIT = 1;
  localparam int TCC_FLAG_BIT = 0;
  // Bits that a control write stores directly
  localparam logic [15:0] TCC_CTRL_WMASK = 16'hF9F4;
  localparam logic [15:0] TCC_CTRL_RESET = 16'h0000;
  localparam logic [15:0] TCC_VAL_RESET = 16'h0000;
  localparam logic [15:0] TCC_IV_NONE = 16'h0000;
  localparam logic [15:0] TCC_IV_OVF = 16'h000E;
  // Capture edge and output mode codes
  localparam logic [1:0] TCC_EDGE_RISE = 2'h1;
  localparam logic [1:0] TCC_EDGE_FALL = 2'h2;
  localparam logic [1:0] TCC_EDGE_BOTH = 2'h3;
  typedef enum logic [2:0] {
    TCC_OM_OUT = 3'h0, TCC_OM_SET = 3'h1, TCC_OM_TGL_RST = 3'h2, TCC_OM_SET_RST = 3'h3,
    TCC_OM_TGL = 3'h4, TCC_OM_RST = 3'h5, TCC_OM_TGL_SET = 3'h6, TCC_OM_RST_SET = 3'h7
  } tcc_outmode_t;

  // Vector code of the highest-priority pending source; pend_ch[k] is channel k+1
  function automatic logic [15:0] tcc_vec_code(input logic [TCC_MAX_CH-2:0] pend_ch,
                                               input logic pend_ovf);
    logic [15:0] code;
    code = pend_ovf ? TCC_IV_OVF : TCC_IV_NONE;
    for (int k = TCC_MAX_CH - 2; k >= 0; k--) begin
      if (pend_ch[k]) begin
        code = 16'(2 * (k + 1));
      end
    end
    return code;
  endfunction : tcc_vec_code
endpackage : tcc_pkg

// File: core/tcc_chan_if.sv
// Signals between the channel register bank and one channel datapath.
// Assumes both ends run on the same timer clock.
`timescale 1ns/1ps
interface tcc_chan_if;
  import tcc_pkg::*;
  logic cap_mode;
  logic [1:0] in_sel;
  logic [1:0] edge_sel;
  logic sync_en;
  logic [2:0] out_mode;
  logic out_bit;
  logic [TCC_CNT_W-1:0] value;
  logic [TCC_CNT_W-1:0] cnt;
  logic cnt_tick;
  logic eq0;
  logic cap_evt;
  logic [TCC_CNT_W-1:0] cap_data;
  logic eq_evt;
  logic in_level;
  logic out_level;
  modport bank (output cap_mode, in_sel, edge_sel, sync_en, out_mode, out_bit, value, cnt,
                cnt_tick, eq0, input cap_evt, cap_data, eq_evt, in_level, out_level);
  modport chan (input cap_mode, in_sel, edge_sel, sync_en, out_mode, out_bit, value, cnt,
                cnt_tick, eq0, output cap_evt, cap_data, eq_evt, in_level, out_level);
endinterface : tcc_chan_if

// File: core/tcc_channel.sv
// One capture/compare channel: input sync, edge detect, compare and output unit.
// Assumes the bank holds the control fields and the channel value.
`timescale 1ns/1ps
module tcc_channel import tcc_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Capture pins
  input wire logic pin_a,
  input wire logic pin_b,
  // Bank side
  tcc_chan_if.chan bus
);
  logic [1:0] sync1, sync2, next_sync1, next_sync2;
  logic prev_sel, next_prev_sel;
  logic held_evt, next_held_evt;
  logic [TCC_CNT_W-1:0] held_cnt, next_held_cnt;
  logic out_q, next_out_q;
  logic sel, raw_evt, match;

  always_comb begin
    next_sync1 = {pin_b, pin_a};
    next_sync2 = sync1;
    case (bus.in_sel) // [R2]
      2'h0: sel = sync2[0];
      2'h1: sel = sync2[1];
      2'h2: sel = 1'b0;
      default: sel = 1'b1;
    endcase
    next_prev_sel = sel;
    // Toggling the low select between ground and supply makes an edge [R7]
    raw_evt = bus.cap_mode && // [R1]
              ((bus.edge_sel[0] && sel && !prev_sel) ||
               (bus.edge_sel[1] && !sel && prev_sel)); // [R2]
    next_held_evt = raw_evt;
    next_held_cnt = bus.cnt;
    match = bus.cnt_tick && (bus.cnt == bus.value); // [R18]
    next_out_q = out_q;
    if (!bus.cap_mode) begin // [R8]
      case (bus.out_mode) // [R10]
        TCC_OM_OUT: next_out_q = bus.out_bit;
        TCC_OM_SET: if (match) next_out_q = 1'b1; // [R12]
        TCC_OM_TGL_RST, TCC_OM_SET_RST: begin // [R13]
          if (match) next_out_q = bus.out_mode[0] ? 1'b1 : !out_q;
          else if (bus.eq0) next_out_q = 1'b0;
        end
        TCC_OM_TGL: if (match) next_out_q = !out_q; // [R15]
        TCC_OM_RST: if (match) next_out_q = 1'b0; // [R16]
        TCC_OM_TGL_SET, TCC_OM_RST_SET: begin // [R14]
          if (match) next_out_q = bus.out_mode[0] ? 1'b0 : !out_q;
          else if (bus.eq0) next_out_q = 1'b1;
        end
        default: next_out_q = out_q;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      prev_sel <= 1'b0;
      held_evt <= 1'b0;
      held_cnt <= TCC_VAL_RESET;
      out_q <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev_sel <= next_prev_sel;
      held_evt <= next_held_evt;
      held_cnt <= next_held_cnt;
      out_q <= next_out_q;
    end
  end

  // Synchronous capture lands one timer edge after the input edge
  // A held event is dropped once the channel has left capture mode
  assign bus.cap_evt = bus.cap_mode && (bus.sync_en ? held_evt : raw_evt); // [R1] [R5]
  assign bus.cap_data = bus.sync_en ? held_cnt : bus.cnt; // [R5]
  assign bus.eq_evt = match && !bus.cap_mode; // [R9]
  assign bus.in_level = sel; // [R4]
  // Mode 0 follows the output bit without waiting for a clock edge
  assign bus.out_level = (bus.out_mode == TCC_OM_OUT) ? bus.out_bit : out_q; // [R11]
endmodule : tcc_channel

// File: core/tcc_capture_compare.sv
// Capture/compare channels of a 16-bit timer with their interrupt logic.
// Assumes the counter, its clock and its direction live outside; count_tick
// marks each cycle in which counter_value took a new value.
//
// What this block does
// [R1] Capture-select set puts the channel into capture mode on its selected input.
// [R2] Input select picks the source; edge field picks rising, falling or both.
// [R3] A capture edge copies the counter into the channel value and sets the flag.
// [R4] The live selected input level is readable through a status bit.
// [R5] With synchronise set, the capture takes effect at the next timer edge.
// [R6] A second unread capture sets overflow; only software clears it.
// [R7] Toggling the low select between ground and supply triggers a software capture.
// [R8] Capture-select clear puts the channel into compare mode.
// [R9] A compare match sets the flag, raises equal and latches the synced input.
// [R10] Outputs change on timer clock edges in every mode except zero.
// [R11] Mode zero drives the output bit straight through, immediately.
// [R12] Mode one sets the output on match and holds it.
// [R13] Modes two and three toggle or set on match, reset on channel-zero match.
// [R14] Modes six and seven toggle or reset on match, set on channel-zero match.
// [R15] Mode four toggles the output on each match.
// [R16] Mode five resets the output on match and holds it.
// [R17] Channel zero's own and channel-zero equal events are one signal.
// [R18] Matches count in either count direction, also for channel zero.
// [R19] Software keeps a mode bit set while changing modes, except into zero.
// [R20] Software may set or clear flags; requests need channel and global enables.
// [R21] Channel zero has top priority, its own request, and auto-clears when serviced.
// [R22] Other flags and overflow share a vector reporting the top enabled source.
// [R23] Any vector access clears the top pending flag; others stay pending.
// [R24] Vector reads zero when idle, 2 to 12 for channels, 14 for overflow.
// [R25] Reading a captured value consumes it for overflow detection.
`timescale 1ns/1ps
module tcc_capture_compare import tcc_pkg::*; #(
  parameter int N = TCC_MAX_CH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Counter
  input wire logic [TCC_CNT_W-1:0] counter_value,
  input wire logic count_tick,
  input wire logic ovf_evt,
  // Pins
  input wire logic [N-1:0] channel_input_a,
  input wire logic [N-1:0] channel_input_b,
  output logic [N-1:0] channel_output,
  // Software access
  input wire logic [15:0] sw_wdata,
  input wire logic [N-1:0] sw_ctrl_wr,
  input wire logic [N-1:0] sw_val_wr,
  input wire logic [N-1:0] sw_val_rd,
  output logic [N-1:0][15:0] ctrl_rdata,
  output logic [N-1:0][TCC_CNT_W-1:0] value_rdata,
  input wire logic ovf_irq_enable,
  input wire logic sw_ovf_wr,
  output logic counter_overflow_flag,
  input wire logic iv_access,
  output logic [15:0] irq_vector_reg,
  // Interrupts
  input wire logic global_irq_enable,
  input wire logic irq0_ack,
  output logic irq_ch0,
  output logic irq_shared
);
  if (N < 1 || N > TCC_MAX_CH) begin : g_bad_n
    $error("tcc_capture_compare: N must be 1 to 7");
  end

  tcc_chan_if chif [N] ();

  logic [N-1:0][15:0] cfg, next_cfg;
  logic [N-1:0][TCC_CNT_W-1:0] val, next_val;
  logic [N-1:0] flag, next_flag;
  logic [N-1:0] cov, next_cov;
  logic [N-1:0] synced_input_bit, next_synced_input_bit;
  logic [N-1:0] unread, next_unread;
  logic ovf, next_ovf;
  logic [15:0] iv, next_iv;
  logic [N-1:0] cap_evt, eq_evt, in_level;
  logic [N-1:0][TCC_CNT_W-1:0] cap_data;
  logic [TCC_MAX_CH-2:0] pend_ch;
  logic [TCC_MAX_CH-2:0] pend_cur;

  for (genvar i = 0; i < N; i++) begin : g_ch
    assign chif[i].cap_mode = cfg[i][TCC_CAP_BIT];
    assign chif[i].in_sel = cfg[i][TCC_CCIS_LSB+:2];
    assign chif[i].edge_sel = cfg[i][TCC_CM_LSB+:2];
    assign chif[i].sync_en = cfg[i][TCC_SCS_BIT];
    assign chif[i].out_mode = cfg[i][TCC_OUTMOD_LSB+:3];
    assign chif[i].out_bit = cfg[i][TCC_OUT_BIT];
    assign chif[i].value = val[i];
    assign chif[i].cnt = counter_value;
    assign chif[i].cnt_tick = count_tick;
    // Channel zero sees its own match as the channel-zero match [R17]
    assign chif[i].eq0 = eq_evt[0];
    assign cap_evt[i] = chif[i].cap_evt;
    assign cap_data[i] = chif[i].cap_data;
    assign eq_evt[i] = chif[i].eq_evt;
    assign in_level[i] = chif[i].in_level;
    assign channel_output[i] = chif[i].out_level;

    tcc_channel u_chan (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin_a(channel_input_a[i]),
      .pin_b(channel_input_b[i]),
      .bus(chif[i])
    );

    assign ctrl_rdata[i] = cfg[i] |
                           (16'(synced_input_bit[i]) << TCC_SYNCED_INPUT_BIT_BIT) |
                           (16'(in_level[i]) << TCC_CCI_BIT) | // [R4]
                           (16'(cov[i]) << TCC_COV_BIT) |
                           (16'(flag[i]) << TCC_FLAG_BIT);
    assign value_rdata[i] = val[i];
  end

  // Pending, enabled shared-vector sources from the registered state
  always_comb begin
    pend_cur = '0;
    for (int i = 1; i < N; i++) begin
      pend_cur[i-1] = flag[i] && cfg[i][TCC_CHANNEL_IRQ_ENABLE_BIT];
    end
  end

  always_comb begin
    next_cfg = cfg;
    next_val = val;
    next_flag = flag;
    next_cov = cov;
    next_synced_input_bit = synced_input_bit;
    next_unread = unread;
    next_ovf = ovf;
    pend_ch = '0;
    for (int i = 0; i < N; i++) begin
      // Software writes: flag and overflow may each be set or cleared [R20]
      if (sw_ctrl_wr[i]) begin
        next_cfg[i] = sw_wdata & TCC_CTRL_WMASK;
        next_flag[i] = sw_wdata[TCC_FLAG_BIT]; // [R20]
        next_cov[i] = sw_wdata[TCC_COV_BIT]; // [R6]
      end
      if (sw_val_wr[i]) begin
        next_val[i] = sw_wdata;
      end
      if (sw_val_rd[i]) begin
        next_unread[i] = 1'b0; // [R25]
      end
      // Servicing channel zero clears its flag [R21]
      if (i == 0 && irq0_ack) begin
        next_flag[i] = 1'b0;
      end
      // Vector access clears only the source it named [R23]
      if (i > 0 && iv_access && iv == 16'(2 * i)) begin
        next_flag[i] = 1'b0;
      end
      // Hardware events win over any clear in the same cycle
      if (cap_evt[i]) begin
        next_val[i] = cap_data[i]; // [R3]
        next_flag[i] = 1'b1; // [R3]
        next_unread[i] = 1'b1;
        if (unread[i] && !sw_val_rd[i]) begin
          next_cov[i] = 1'b1; // [R6]
        end
      end
      if (eq_evt[i]) begin
        next_flag[i] = 1'b1; // [R9]
        next_synced_input_bit[i] = in_level[i]; // [R9]
      end
    end
    if (sw_ovf_wr) begin
      next_ovf = sw_wdata[TCC_FLAG_BIT];
    end
    if (iv_access && iv == TCC_IV_OVF) begin
      next_ovf = 1'b0; // [R23]
    end
    if (ovf_evt) begin
      next_ovf = 1'b1;
    end
    for (int i = 1; i < N; i++) begin
      pend_ch[i-1] = next_flag[i] && next_cfg[i][TCC_CHANNEL_IRQ_ENABLE_BIT]; // [R22]
    end
    // Disabled sources never reach the code [R22]
    next_iv = tcc_vec_code(pend_ch, next_ovf && ovf_irq_enable); // [R24]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg <= {N{TCC_CTRL_RESET}};
      val <= {N{TCC_VAL_RESET}};
      flag <= '0;
      cov <= '0;
      synced_input_bit <= '0;
      unread <= '0;
      ovf <= 1'b0;
      iv <= TCC_IV_NONE;
    end else begin
      cfg <= next_cfg;
      val <= next_val;
      flag <= next_flag;
      cov <= next_cov;
      synced_input_bit <= next_synced_input_bit;
      unread <= next_unread;
      ovf <= next_ovf;
      iv <= next_iv;
    end
  end

  assign irq_vector_reg = iv;
  assign counter_overflow_flag = ovf;
  // Channel zero has its own request line [R21]
  assign irq_ch0 = flag[0] && cfg[0][TCC_CHANNEL_IRQ_ENABLE_BIT] && global_irq_enable; // [R20]
  // Any further pending source re-raises the shared request [R23]
  assign irq_shared = ((|pend_cur) || (ovf && ovf_irq_enable)) && global_irq_enable;
endmodule : tcc_capture_compare

// File: test/tcc_far_model.sv
// Far-side model: the counter that feeds the capture/compare block.
// Assumes the bench starts, stops and clears it between scenarios.
`timescale 1ns/1ps
module tcc_far_model import tcc_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bench control
  input wire logic run,
  input wire logic clr,
  // Counter outputs
  output logic [TCC_CNT_W-1:0] counter_value,
  output logic count_tick,
  output logic ovf_evt
);
  always_ff @(posedge core_clk) begin
    if (!rst_b || clr) begin
      counter_value <= '0;
      count_tick <= 1'b0;
      ovf_evt <= 1'b0;
    end else begin
      // Up count; the wrap to zero is the overflow event
      counter_value <= counter_value + TCC_CNT_W'(run);
      count_tick <= run;
      ovf_evt <= run && counter_value == '1;
    end
  end
endmodule : tcc_far_model

// File: test/tcc_capture_compare_asserts.sv
// Checker on the top-level ports of the capture/compare block.
// Assumes one timer clock and at least two channels.
`timescale 1ns/1ps
module tcc_capture_compare_asserts import tcc_pkg::*; #(
  parameter int N = TCC_MAX_CH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Inputs watched
  input wire logic [TCC_CNT_W-1:0] counter_value,
  input wire logic count_tick,
  input wire logic ovf_evt,
  input wire logic [N-1:0] sw_ctrl_wr,
  input wire logic sw_ovf_wr,
  input wire logic iv_access,
  input wire logic global_irq_enable,
  input wire logic irq0_ack,
  // Outputs watched
  input wire logic [N-1:0] channel_output,
  input wire logic [N-1:0][15:0] ctrl_rdata,
  input wire logic [N-1:0][TCC_CNT_W-1:0] value_rdata,
  input wire logic counter_overflow_flag,
  input wire logic [15:0] irq_vector_reg,
  input wire logic irq_ch0
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [2:0] mode1;
  logic hit0;
  assign mode1 = ctrl_rdata[1][7:5];
  assign hit0 = count_tick && counter_value == value_rdata[0] && !ctrl_rdata[0][8];
  sequence own_hit_s;
    count_tick && counter_value == value_rdata[1] && !ctrl_rdata[1][8] && !sw_ctrl_wr[1];
  endsequence
  sequence zero_hit_s;
    hit0 && counter_value != value_rdata[1] && !ctrl_rdata[1][8] && !sw_ctrl_wr[1];
  endsequence
  mode_zero_a: assert property (mode1 == 3'h0 |-> channel_output[1] == ctrl_rdata[1][2])
    else $error("mode 0 output differs from bit");
  match_flag_a: assert property (own_hit_s |=> ctrl_rdata[1][0])
    else $error("match did not set flag");
  set_mode_a: assert property (own_hit_s ##0 mode1 == 3'h1 |=> channel_output[1])
    else $error("set mode output low");
  toggle_mode_a: assert property (own_hit_s ##0 mode1 == 3'h4
    |=> channel_output[1] != $past(channel_output[1])) else $error("no toggle");
  reset_mode_a: assert property (own_hit_s ##0 mode1 == 3'h5 |=> !channel_output[1])
    else $error("reset mode output high");
  zero_match_a: assert property (zero_hit_s ##0 (mode1 == 3'h3 || mode1 == 3'h7)
    |=> channel_output[1] == $past(mode1[2])) else $error("zero match output wrong");
  irq0_gate_a: assert property (irq_ch0 == (ctrl_rdata[0][0] && ctrl_rdata[0][4]
    && global_irq_enable)) else $error("channel 0 request wrong");
  ack_clear_a: assert property (irq0_ack && !sw_ctrl_wr[0] && !ctrl_rdata[0][8] && !hit0
    |=> !ctrl_rdata[0][0]) else $error("ack kept channel 0 flag");
  vector_code_a: assert property (!irq_vector_reg[0] && irq_vector_reg <= 16'h000E)
    else $error("vector code out of range");
  vector_clear_a: assert property (iv_access && irq_vector_reg == 16'h000E && !sw_ovf_wr
    && !ovf_evt |=> !counter_overflow_flag) else $error("access kept overflow flag");
endmodule : tcc_capture_compare_asserts

bind tcc_capture_compare tcc_capture_compare_asserts #(.N(N)) i_tcc_capture_compare_asserts (
  .core_clk(core_clk), .rst_b(rst_b), .counter_value(counter_value),
  .count_tick(count_tick), .ovf_evt(ovf_evt), .sw_ctrl_wr(sw_ctrl_wr), .sw_ovf_wr(sw_ovf_wr),
  .iv_access(iv_access), .global_irq_enable(global_irq_enable), .irq0_ack(irq0_ack),
  .channel_output(channel_output), .ctrl_rdata(ctrl_rdata), .value_rdata(value_rdata),
  .counter_overflow_flag(counter_overflow_flag), .irq_vector_reg(irq_vector_reg),
  .irq_ch0(irq_ch0));

// File: test/test_tcc_capture_compare.sv
// Self-checking bench for the capture/compare block.
// Assumes the counter model feeds the count; software strobes are pulsed here.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected %s: expected %0h, seen %0h", what, exp, got); end end
module test_tcc_capture_compare;
  import tcc_pkg::*;
  typedef struct packed {logic [2:0] m; logic s; logic a; logic b;} tcc_row_t;
  logic core_clk, rst_b, run, clr, sw_ovf_wr, iv_access, irq0_ack, ovf_irq_enable;
  logic global_irq_enable, count_tick, ovf_evt, ovf_flag, irq_ch0, irq_shared;
  logic [TCC_CNT_W-1:0] counter_value;
  logic [15:0] sw_wdata, irq_vector_reg;
  logic [6:0] ctrl_wr, val_wr, val_rd, chan_out, pin_a, pin_b;
  logic [6:0][15:0] ctrl_rd;
  logic [6:0][TCC_CNT_W-1:0] value_rd;
  int errors, cmp_count;
  // Mode, start level, level after own match, level after channel-zero match
  tcc_row_t rows [11] = '{6'h00, 6'h07, 6'h0B, 6'h12, 6'h14, 6'h1A, 6'h23, 6'h24, 6'h2C,
    6'h33, 6'h3D};
  tcc_far_model i_tcc_far_model (.core_clk(core_clk), .rst_b(rst_b), .run(run), .clr(clr),
    .counter_value(counter_value), .count_tick(count_tick), .ovf_evt(ovf_evt));
  tcc_capture_compare #(.N(7)) i_tcc_capture_compare (.core_clk(core_clk), .rst_b(rst_b),
    .counter_value(counter_value), .count_tick(count_tick), .ovf_evt(ovf_evt),
    .channel_input_a(pin_a), .channel_input_b(pin_b), .channel_output(chan_out),
    .sw_wdata(sw_wdata), .sw_ctrl_wr(ctrl_wr), .sw_val_wr(val_wr), .sw_val_rd(val_rd),
    .ctrl_rdata(ctrl_rd), .value_rdata(value_rd), .ovf_irq_enable(ovf_irq_enable),
    .sw_ovf_wr(sw_ovf_wr), .counter_overflow_flag(ovf_flag), .iv_access(iv_access),
    .irq_vector_reg(irq_vector_reg), .global_irq_enable(global_irq_enable),
    .irq0_ack(irq0_ack), .irq_ch0(irq_ch0), .irq_shared(irq_shared));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    give_verdict();
  end
  task automatic step(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask : step
  // Kind: 0 control, 1 value, 2 value read, 3 overflow flag, 4 vector access
  task automatic sw(input int kind, input int ch, input logic [15:0] d);
    sw_wdata = d;
    case (kind)
      0: ctrl_wr[ch] = 1'b1;
      1: val_wr[ch] = 1'b1;
      2: val_rd[ch] = 1'b1;
      3: sw_ovf_wr = 1'b1;
      default: iv_access = 1'b1;
    endcase
    step(1);
    {ctrl_wr, val_wr, val_rd, sw_ovf_wr, iv_access} = '0;
    step(1);
  endtask : sw
  task automatic count(input int n);
    run = 1'b1;
    step(n);
    run = 1'b0;
    step(2);
  endtask : count
  initial begin
    {rst_b, run, clr, sw_ovf_wr, iv_access, irq0_ack, ctrl_wr, val_wr, val_rd, sw_wdata} = '0;
    {ovf_irq_enable, global_irq_enable} = 2'h3;
    {pin_a, pin_b} = '0;
    errors = 0;
    cmp_count = 0;
    step(4);
    rst_b = 1'b1;
    `CHK("outputs", 7'h00, chan_out)
    `CHK("vector", 16'h0000, irq_vector_reg)
    sw(1, 1, 16'h0005);
    sw(1, 0, 16'h0009);
    foreach (rows[r]) begin
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      sw(0, 1, {13'h0000, rows[r].s, 2'h0});
      `CHK("mode 0 out", rows[r].s, chan_out[1])
      // Leaving mode 0 in one write, so no intermediate mode is decoded
      sw(0, 1, {8'h00, rows[r].m, 2'h0, rows[r].s, 2'h0});
      count(7);
      `CHK("own match out", rows[r].a, chan_out[1])
      `CHK("match flag", 1'b1, ctrl_rd[1][0])
      count(4);
      `CHK("zero match out", rows[r].b, chan_out[1])
    end
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    count(3);
    sw(0, 2, 16'hE900);
    sw(0, 2, 16'hF900);
    step(6);
    `CHK("capture", 16'h0003, value_rd[2])
    `CHK("capture flag", 1'b1, ctrl_rd[2][0])
    `CHK("input level", 1'b1, ctrl_rd[2][3])
    `CHK("overflow", 1'b0, ctrl_rd[2][1])
    count(2);
    sw(0, 2, 16'hE900);
    step(6);
    `CHK("capture", 16'h0005, value_rd[2])
    `CHK("overflow", 1'b1, ctrl_rd[2][1])
    sw(2, 2, 16'h0000);
    sw(0, 2, 16'hE900);
    `CHK("overflow", 1'b0, ctrl_rd[2][1])
    count(1);
    sw(0, 2, 16'hF900);
    step(6);
    `CHK("capture", 16'h0006, value_rd[2])
    `CHK("overflow", 1'b0, ctrl_rd[2][1])
    sw(0, 1, 16'h0001);
    for (int k = 2; k < 7; k++) begin
      sw(0, k, 16'h0011);
    end
    sw(3, 0, 16'h0001);
    `CHK("overflow flag", 1'b1, ovf_flag)
    for (int k = 2; k < 7; k++) begin
      `CHK("vector", 16'(2 * k), irq_vector_reg)
      `CHK("shared irq", 1'b1, irq_shared)
      sw(4, 0, 16'h0000);
    end
    `CHK("vector", 16'h000E, irq_vector_reg)
    sw(4, 0, 16'h0000);
    `CHK("vector", 16'h0000, irq_vector_reg)
    `CHK("shared irq", 1'b0, irq_shared)
    `CHK("overflow flag", 1'b0, ovf_flag)
    `CHK("ch1 flag", 1'b1, ctrl_rd[1][0])
    sw(0, 0, 16'h0011);
    `CHK("ch0 irq", 1'b1, irq_ch0)
    global_irq_enable = 1'b0;
    step(1);
    `CHK("ch0 irq", 1'b0, irq_ch0)
    global_irq_enable = 1'b1;
    irq0_ack = 1'b1;
    step(1);
    irq0_ack = 1'b0;
    step(1);
    `CHK("ch0 flag", 1'b0, ctrl_rd[0][0])
    // Pin captures: rising on input b without sync, falling on input a with sync
    sw(0, 3, 16'h5100);
    pin_b[3] = 1'b1;
    step(4);
    `CHK("pin capture", 16'h0006, value_rd[3])
    `CHK("pin level", 1'b1, ctrl_rd[3][3])
    sw(0, 3, 16'h5100);
    pin_b[3] = 1'b0;
    step(4);
    `CHK("falling ignored", 1'b0, ctrl_rd[3][0])
    pin_a[4] = 1'b1;
    step(3);
    sw(0, 4, 16'h8900);
    pin_a[4] = 1'b0;
    step(5);
    `CHK("sync capture", 16'h0006, value_rd[4])
    `CHK("sync flag", 1'b1, ctrl_rd[4][0])
    give_verdict();
  end
endmodule : test_tcc_capture_compare
